// ### hdl/shpcb_bank.v
// shadowed control bank at one management location, with its serial management slave
`timescale 1ns/1ps
`include "shpcb_defs.vh"
module shpcb_bank (
  input wire core_clk,
  input wire srst,
  input wire [4:0] port_addr,
  input wire mdc_i,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe,
  output wire ext_loopback,
  output wire ext_packet_length,
  output wire [1:0] gig_edge_rate,
  output wire [1:0] fast_edge_rate,
  output wire tx_normal_mode,
  output wire prf_disable,
  output wire line_loopback,
  output wire same_pair_test_mode,
  output wire packet_count_rx,
  output wire automatic_crossover_detection_forced,
  output wire speed_downgrade_en
);
  localparam [1:0] ST_PRE = 2'h0;
  localparam [1:0] ST_HDR = 2'h1;
  localparam [1:0] ST_TA = 2'h2;
  localparam [1:0] ST_DATA = 2'h3;

  wire [12:0] aux_q;
  wire [12:0] pwr_q;
  wire [12:0] tst_q;
  wire [12:0] misc_q;

  reg mdc_q;
  reg [1:0] state_q;
  reg [5:0] cnt_q;
  reg [13:0] hdr_q;
  reg [15:0] data_q;
  reg mine_q;
  reg rd_q;
  reg [15:0] addr_q;

  wire mdc_rise;
  wire [13:0] hdr_next;
  wire [15:0] wdata;
  wire [1:0] op;
  wire bank_we;
  reg [12:0] misc_mask;

  // word of a shadow: stored upper bits plus its own code in 2:0
  function [15:0] shadow_word;
    input [12:0] up;
    input [2:0] code;
    begin
      shadow_word = {up, code};
    end
  endfunction

  // read word of the location, steered by the held read selector
  function [15:0] read_word;
    input [15:0] addr;
    input [12:0] aux;
    input [12:0] pwr;
    input [12:0] tst;
    input [12:0] misc;
    reg [2:0] rsel;
    begin
      rsel = misc[`SHPCB_B_RSEL_HI-`SHPCB_UP_LSB:`SHPCB_B_RSEL_LO-`SHPCB_UP_LSB];
      read_word = 16'h0000;
      if (addr == `SHPCB_LOC_ADDR) begin
        case (rsel)
          `SHPCB_SEL_AUX: read_word = shadow_word(aux, `SHPCB_SEL_AUX);
          `SHPCB_SEL_PWR: read_word = shadow_word(pwr, `SHPCB_SEL_PWR);
          `SHPCB_SEL_TST: read_word = shadow_word(tst, `SHPCB_SEL_TST);
          `SHPCB_SEL_MISC: read_word = shadow_word(misc, `SHPCB_SEL_MISC);
          default: read_word = 16'h0000;
        endcase
      end
    end
  endfunction

  // write strobe for one shadow: a bank write whose low code names it
  function sel_hit;
    input we;
    input [2:0] code;
    input [2:0] sel;
    begin
      sel_hit = we && (code == sel);
    end
  endfunction

  // one control bit of a shadow, by its position in the word
  function word_bit;
    input [12:0] up;
    input integer pos;
    begin
      word_bit = up[pos - `SHPCB_UP_LSB];
    end
  endfunction

  // two-bit control field of a shadow, by its word positions
  function [1:0] word_pair;
    input [12:0] up;
    input integer hi;
    input integer lo;
    begin
      word_pair = {word_bit(up, hi), word_bit(up, lo)};
    end
  endfunction

  // next serial word after one bit leaves at the top
  function [15:0] shift_up;
    input [15:0] w;
    begin
      shift_up = {w[14:0], 1'b0};
    end
  endfunction

  assign mdc_rise = mdc_i & ~mdc_q;
  assign hdr_next = {hdr_q[12:0], mdio_i};
  assign wdata = {data_q[14:0], mdio_i};
  assign op = hdr_q[11:10];
  assign bank_we = mdc_rise && (state_q == ST_DATA) && (cnt_q == `SHPCB_DATA_LAST) &&
                   !rd_q && mine_q && (op == `SHPCB_OP_WRITE) && (addr_q == `SHPCB_LOC_ADDR);

  // write-enable bit decides how much of the control shadow is taken
  always @* begin
    if (wdata[`SHPCB_B_WE]) begin
      misc_mask = `SHPCB_MASK_MISC_WE;
    end else begin
      misc_mask = `SHPCB_MASK_MISC_NWE;
    end
  end

  // shadow storage; the low code of each write picks one, others ignored
  shpcb_shadow #(.RESET_VAL(`SHPCB_AUX_RST)) u_aux (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(sel_hit(bank_we, wdata[2:0], `SHPCB_SEL_AUX)),
    .wr_mask(`SHPCB_MASK_ALL),
    .wr_data(wdata[15:3]),
    .q(aux_q)
  );
  shpcb_shadow #(.RESET_VAL(`SHPCB_PWR_RST)) u_pwr (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(sel_hit(bank_we, wdata[2:0], `SHPCB_SEL_PWR)),
    .wr_mask(`SHPCB_MASK_ALL),
    .wr_data(wdata[15:3]),
    .q(pwr_q)
  );
  shpcb_shadow #(.RESET_VAL(`SHPCB_TST_RST)) u_tst (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(sel_hit(bank_we, wdata[2:0], `SHPCB_SEL_TST)),
    .wr_mask(`SHPCB_MASK_ALL),
    .wr_data(wdata[15:3]),
    .q(tst_q)
  );
  shpcb_shadow #(.RESET_VAL(`SHPCB_MISC_RST)) u_misc (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(sel_hit(bank_we, wdata[2:0], `SHPCB_SEL_MISC)),
    .wr_mask(misc_mask),
    .wr_data(wdata[15:3]),
    .q(misc_q)
  );

  // control fields taken straight from shadow flops
  assign ext_loopback = word_bit(aux_q, `SHPCB_B_EXT_LB);
  assign ext_packet_length = word_bit(aux_q, `SHPCB_B_EXT_LEN);
  assign gig_edge_rate = word_pair(aux_q, `SHPCB_B_GER_HI, `SHPCB_B_GER_LO);
  assign fast_edge_rate = word_pair(aux_q, `SHPCB_B_FER_HI, `SHPCB_B_FER_LO);
  assign tx_normal_mode = word_bit(aux_q, `SHPCB_B_TX_NORM);
  assign prf_disable = word_bit(aux_q, `SHPCB_B_PRF_DIS);
  assign line_loopback = word_bit(tst_q, `SHPCB_B_LINE_LB);
  assign same_pair_test_mode = word_bit(tst_q, `SHPCB_B_SAME_PAIR);
  assign packet_count_rx = word_bit(misc_q, `SHPCB_B_PKT_RX);
  assign automatic_crossover_detection_forced = word_bit(misc_q, `SHPCB_B_XOVER);
  assign speed_downgrade_en = word_bit(misc_q, `SHPCB_B_DOWNGRADE);

  // clock edge detector; reset high so a clock already high at release is no edge
  always @(posedge core_clk) begin
    if (srst) begin
      mdc_q <= 1'b1;
    end else begin
      mdc_q <= mdc_i;
    end
  end

  // management frame receiver and read driver
  always @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_PRE;
      cnt_q <= 6'h00;
      hdr_q <= 14'h0000;
      data_q <= 16'h0000;
      mine_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= `SHPCB_ADDR_RST;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      if (mdc_rise) begin
        case (state_q)
          ST_PRE: begin
            if (mdio_i) begin
              if (cnt_q < `SHPCB_PRE_MIN) begin
                cnt_q <= cnt_q + 6'h01;
              end
            end else if (cnt_q >= `SHPCB_PRE_MIN) begin
              state_q <= ST_HDR;
              hdr_q <= hdr_next;
              cnt_q <= 6'h01;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr_q <= hdr_next;
            if (cnt_q == `SHPCB_HDR_LAST) begin
              if (hdr_next[13:12] != `SHPCB_ST_C45) begin
                state_q <= ST_PRE;
                cnt_q <= 6'h00;
              end else begin
                state_q <= ST_TA;
                cnt_q <= 6'h00;
                rd_q <= hdr_next[11];
                mine_q <= (hdr_next[9:5] == port_addr) && (hdr_next[4:0] == `SHPCB_DEVICE_ADDRESS_SPACE);
                data_q <= read_word(addr_q, aux_q, pwr_q, tst_q, misc_q);
              end
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          ST_TA: begin
            if (cnt_q == `SHPCB_TA_LAST) begin
              state_q <= ST_DATA;
              cnt_q <= 6'h00;
              if (rd_q && mine_q) begin
                mdio_o <= data_q[15];
                data_q <= shift_up(data_q);
              end
            end else begin
              cnt_q <= cnt_q + 6'h01;
              if (rd_q && mine_q) begin
                mdio_oe <= 1'b1;
                mdio_o <= 1'b0;
              end
            end
          end
          ST_DATA: begin
            if (rd_q) begin
              mdio_o <= data_q[15];
              data_q <= shift_up(data_q);
            end else begin
              data_q <= wdata;
            end
            if (cnt_q == `SHPCB_DATA_LAST) begin
              state_q <= ST_PRE;
              cnt_q <= 6'h00;
              mdio_oe <= 1'b0;
              mdio_o <= 1'b0;
              if (mine_q && (op == `SHPCB_OP_ADDR)) begin
                addr_q <= wdata;
              end
              if (mine_q && (op == `SHPCB_OP_RINC)) begin
                addr_q <= addr_q + 16'h0001;
              end
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          default: begin
            state_q <= ST_PRE;
            cnt_q <= 6'h00;
          end
        endcase
      end
    end
  end
endmodule

// ### hdl/shpcb_defs.vh
// constants for the shadowed control bank and its management port
`ifndef SHPCB_DEFS_VH
`define SHPCB_DEFS_VH

// management location
`define SHPCB_DEVICE_ADDRESS_SPACE 5'h07
`define SHPCB_LOC_ADDR 16'hFFF8
`define SHPCB_ADDR_RST 16'h0000

// management frame
`define SHPCB_PRE_MIN 6'h20
`define SHPCB_HDR_LAST 6'h0D
`define SHPCB_DATA_LAST 6'h0F
`define SHPCB_TA_LAST 6'h01
`define SHPCB_ST_C45 2'h0
`define SHPCB_OP_ADDR 2'h0
`define SHPCB_OP_WRITE 2'h1
`define SHPCB_OP_RINC 2'h2
`define SHPCB_OP_READ 2'h3

// shadow select codes
`define SHPCB_SEL_AUX 3'h0
`define SHPCB_SEL_PWR 3'h2
`define SHPCB_SEL_TST 3'h4
`define SHPCB_SEL_MISC 3'h7

// upper 13 bits stored per shadow: index n holds word bit n+3
`define SHPCB_AUX_RST 13'h0880
`define SHPCB_PWR_RST 13'h0000
`define SHPCB_TST_RST 13'h0000
`define SHPCB_MISC_RST 13'h0000

// write masks on the stored upper field
`define SHPCB_MASK_ALL 13'h1FFF
`define SHPCB_MASK_MISC_WE 13'h0FFF
`define SHPCB_MASK_MISC_NWE 13'h0E00

// word bit positions
`define SHPCB_B_WE 15
`define SHPCB_B_EXT_LB 15
`define SHPCB_B_EXT_LEN 14
`define SHPCB_B_GER_HI 13
`define SHPCB_B_GER_LO 12
`define SHPCB_B_TX_NORM 10
`define SHPCB_B_PRF_DIS 7
`define SHPCB_B_FER_HI 5
`define SHPCB_B_FER_LO 4
`define SHPCB_B_LINE_LB 15
`define SHPCB_B_SAME_PAIR 4
`define SHPCB_B_RSEL_HI 14
`define SHPCB_B_RSEL_LO 12
`define SHPCB_B_PKT_RX 11
`define SHPCB_B_XOVER 9
`define SHPCB_B_DOWNGRADE 4
`define SHPCB_UP_LSB 3

`endif

// ### hdl/shpcb_shadow.v
// one shadow register: upper 13 bits with a per-bit write mask
`timescale 1ns/1ps
module shpcb_shadow #(
  parameter [12:0] RESET_VAL = 13'h0000
) (
  input wire core_clk,
  input wire srst,
  input wire wr_en,
  input wire [12:0] wr_mask,
  input wire [12:0] wr_data,
  output reg [12:0] q
);
  always @(posedge core_clk) begin
    if (srst) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= (q & ~wr_mask) | (wr_data & wr_mask);
    end
  end
endmodule

// ### sim/shpcb_bank_checker.sv
// timing checks on the management answer and the control outputs
`timescale 1ns/1ps
module shpcb_bank_checker (
  input wire core_clk,
  input wire srst,
  input wire mdc_i,
  input wire mdio_o,
  input wire mdio_oe,
  input wire ext_loopback,
  input wire ext_packet_length,
  input wire [1:0] gig_edge_rate,
  input wire [1:0] fast_edge_rate,
  input wire tx_normal_mode,
  input wire prf_disable,
  input wire line_loopback,
  input wire same_pair_test_mode,
  input wire packet_count_rx,
  input wire automatic_crossover_detection_forced,
  input wire speed_downgrade_en
);
  wire [12:0] ctrl = {ext_loopback, ext_packet_length, gig_edge_rate, fast_edge_rate,
    tx_normal_mode, prf_disable, line_loopback, same_pair_test_mode, packet_count_rx,
    automatic_crossover_detection_forced, speed_downgrade_en};
  reg mdc_q;
  reg [3:0] since_q;
  // core clocks since the last management clock rise, saturating
  always @(posedge core_clk) begin
    if (srst) begin
      mdc_q <= 1'b0;
      since_q <= 4'hF;
    end else begin
      mdc_q <= mdc_i;
      since_q <= (mdc_i & ~mdc_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_turnaround;
    mdio_oe && !mdio_o;
  endsequence
  sequence s_answer;
    mdio_oe [*7];
  endsequence
  a_reset_defaults: assert property ($fell(srst) |-> ctrl == 13'h0840 && !mdio_oe)
    else $error("outputs not at defaults");
  a_ctrl_at_rise: assert property ($changed(ctrl) |-> since_q <= 4'h3)
    else $error("control changed away from a clock rise");
  a_oe_at_rise: assert property ($rose(mdio_oe) |-> since_q <= 4'h2)
    else $error("drive began away from a clock rise");
  a_answer_shape: assert property ($rose(mdio_oe) |-> s_turnaround ##1 s_answer)
    else $error("turnaround or answer malformed");
  a_bit_at_rise: assert property (mdio_oe && $past(mdio_oe) && $changed(mdio_o) |->
    since_q <= 4'h2)
    else $error("data bit moved away from a clock rise");
  a_oe_drop: assert property ($fell(mdio_oe) |-> since_q <= 4'h2)
    else $error("drive ended away from a clock rise");
  a_oe_span: assert property ($fell(mdio_oe) |-> $past(mdio_oe, 8))
    else $error("answer too short");
  a_quiet_read: assert property (mdio_oe |-> $stable(ctrl))
    else $error("control changed during a read");
endmodule

// ### sim/shpcb_host.sv
// management host model driving frames to the bank
`timescale 1ns/1ps
`include "shpcb_defs.vh"
module shpcb_host #(
  parameter [4:0] PRTAD = 5'h05
) (
  input wire core_clk,
  input wire mdio_line,
  output reg mdc,
  output reg host_oe,
  output reg host_bit
);
  initial begin
    mdc = 1'b0;
    host_oe = 1'b0;
    host_bit = 1'b1;
  end
  // one clock period, three core clocks a half; line sampled before the rise
  task bit_cyc(input reg b, input reg oe, output reg seen);
    begin
      mdc = 1'b0;
      host_oe = oe;
      host_bit = b;
      repeat (3) @(negedge core_clk);
      seen = mdio_line;
      mdc = 1'b1;
      repeat (3) @(negedge core_clk);
    end
  endtask
  task frame(input reg [1:0] op, input reg [15:0] wd, output reg [15:0] rd);
    reg [31:0] w;
    reg s;
    integer i;
    begin
      w = {`SHPCB_ST_C45, op, PRTAD, `SHPCB_DEVICE_ADDRESS_SPACE, 2'b10, wd};
      for (i = 0; i < 32; i = i + 1) bit_cyc(1'b1, 1'b1, s);
      for (i = 31; i >= 0; i = i - 1) begin
        bit_cyc(w[i], ((op != `SHPCB_OP_READ) && (op != `SHPCB_OP_RINC)) || (i > 17), s);
        if (i < 16) rd[i] = s;
      end
      host_oe = 1'b0;
    end
  endtask
  task wr(input reg [15:0] d);
    reg [15:0] x;
    frame(`SHPCB_OP_WRITE, d, x);
  endtask
  task rd(input reg [2:0] z, output reg [15:0] d);
    begin
      wr({1'b0, z, 9'h000, `SHPCB_SEL_MISC});
      frame(`SHPCB_OP_READ, 16'h0000, d);
    end
  endtask
  task set_addr;
    reg [15:0] x;
    frame(`SHPCB_OP_ADDR, `SHPCB_LOC_ADDR, x);
  endtask
endmodule

// ### sim/test_shpcb_bank.sv
// self-checking bench for the shadowed control bank
`timescale 1ns/1ps
module test_shpcb_bank;
  reg core_clk;
  reg srst;
  wire mdc, host_oe, host_bit, mdio_o, mdio_oe, mdio_line;
  wire [1:0] ger, fer;
  wire elb, elen, txn, prf, llb, spt, pkt, xo, dg;
  wire [12:0] pins = {elb, elen, ger, fer, txn, prf, llb, spt, pkt, xo, dg};
  reg [15:0] v;
  integer n_fail, n_compared, i;
  // line pulled up while nobody drives it
  assign mdio_line = mdio_oe ? mdio_o : (host_oe ? host_bit : 1'b1);
  shpcb_host host (.core_clk(core_clk), .mdio_line(mdio_line), .mdc(mdc), .host_oe(host_oe),
    .host_bit(host_bit));
  shpcb_bank uut (.core_clk(core_clk), .srst(srst), .port_addr(5'h05), .mdc_i(mdc),
    .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .ext_loopback(elb),
    .ext_packet_length(elen), .gig_edge_rate(ger), .fast_edge_rate(fer), .tx_normal_mode(txn),
    .prf_disable(prf), .line_loopback(llb), .same_pair_test_mode(spt), .packet_count_rx(pkt),
    .automatic_crossover_detection_forced(xo), .speed_downgrade_en(dg));
  task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rdc(input [2:0] z, input [15:0] exp);
    begin
      host.rd(z, v);
      check("shadow", v, exp);
    end
  endtask
  task do_reset;
    begin
      srst = 1'b1;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      host.set_addr;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    stop_test;
  end
  initial begin
    srst = 1'b1;
    n_fail = 0;
    n_compared = 0;
    @(negedge core_clk);
    do_reset;
    check("pins", {3'h0, pins}, 16'h0840);
    rdc(3'h0, 16'h4400);
    rdc(3'h2, 16'h0002);
    rdc(3'h4, 16'h0004);
    rdc(3'h7, 16'h7007);
    for (i = 0; i < 4; i = i + 1) begin
      host.wr({2'b01, i[1:0], 6'b010000, i[1:0], 4'h0});
      check("edge", {12'h000, ger, fer}, {12'h000, i[1:0], i[1:0]});
    end
    host.wr(16'hB0A0);
    check("pins", {3'h0, pins}, 16'h1720);
    rdc(3'h0, 16'hB0A0);
    for (i = 1; i < 7; i = i + 1) begin
      if (i != 2 && i != 4) begin
        host.wr({13'h1FFF, i[2:0]});
        check("pins", {3'h0, pins}, 16'h1720);
        rdc(3'h0, 16'hB0A0);
        rdc(3'h2, 16'h0002);
        rdc(i[2:0], 16'h0000);
      end
    end
    host.wr(16'h8A17);
    check("pins", {3'h0, pins}, 16'h1727);
    rdc(3'h7, 16'h7A17);
    check("pins", {3'h0, pins}, 16'h1727);
    host.wr(16'h8014);
    check("pins", {3'h0, pins}, 16'h173F);
    rdc(3'h4, 16'h8014);
    host.frame(2'h0, 16'hFFF7, v);
    host.wr(16'h8000);
    check("pins", {3'h0, pins}, 16'h173F);
    host.frame(2'h2, 16'h0000, v);
    check("other location", v, 16'h0000);
    host.frame(2'h3, 16'h0000, v);
    check("after increment", v, 16'h8014);
    do_reset;
    check("pins", {3'h0, pins}, 16'h0840);
    host.frame(2'h3, 16'h0000, v);
    check("reset selector", v, 16'h4400);
    rdc(3'h0, 16'h4400);
    stop_test;
  end
endmodule
bind shpcb_bank shpcb_bank_checker chk (.core_clk, .srst, .mdc_i, .mdio_o, .mdio_oe,
  .ext_loopback, .ext_packet_length, .gig_edge_rate, .fast_edge_rate, .tx_normal_mode,
  .prf_disable, .line_loopback, .same_pair_test_mode, .packet_count_rx,
  .automatic_crossover_detection_forced, .speed_downgrade_en);
